// ### verilog/ssr_defs.svh
// Constants for the status byte and service request logic.
// Behaviour
// - Bit 6 of the service request enable register ignores writes and reads zero.
// - Status byte error-queue bit is high while the error queue holds entries.
// - Status byte mav bit is high while the output queue holds bytes.
// - A new reason for service sets rqs and raises the service request.
// - rqs clears when mss goes false or on a serial poll.
// - Clear-status clears all event registers and empties the error queue.
// - Each of three groups has condition, enable and event registers, all readable.
// - Status and enable queries return unsigned integer values.
// - Status byte carries hardware, coupling and instrument summary bits.
// - Status byte esb summarises standard event register masked by its enable.
// - Bit 0 unused, bits 1-3 instrument/coupling/hardware, 4 mav, 5 esb, 7 error.
// - mss is true when status byte AND enable is nonzero; read in bit 6.
// - Event bits latch on their transition until read or clear-status.
// - Enable registers clear at power-on and survive clear-status.
`ifndef SSR_DEFS_SVH
`define SSR_DEFS_SVH
`define SSR_BW        8
`define SSR_EW        16
`define SSR_QW        8
`define SSR_STB_UNUSED 0
`define SSR_STB_ISB   1
`define SSR_STB_CSB   2
`define SSR_STB_HSB   3
`define SSR_STB_MAV   4
`define SSR_STB_ESB   5
`define SSR_STB_MSS   6
`define SSR_STB_ERB   7
`define SSR_SRE_MASK  8'hBF
`define SSR_ZERO8     8'h00
`define SSR_ZERO16    16'h0000
`define SSR_HW_POS    16'hFFFF
`define SSR_CP_POS    16'hFFFF
`define SSR_IN_POS    16'hFFFF
`endif

// ### verilog/ssr_pkg.sv
// Types shared by the status byte and service request logic.
`default_nettype none
package ssr_pkg;
   // Selects which status value a query returns.
   typedef enum logic [3:0] {
      SSR_Q_STB = 4'b0000,
      SSR_Q_SRE = 4'b0001,
      SSR_Q_ESE = 4'b0010,
      SSR_Q_ESR = 4'b0011,
      SSR_Q_HCR = 4'b0100,
      SSR_Q_HSE = 4'b0101,
      SSR_Q_HSR = 4'b0110,
      SSR_Q_CCR = 4'b0111,
      SSR_Q_CSE = 4'b1000,
      SSR_Q_CSR = 4'b1001,
      SSR_Q_ICR = 4'b1010,
      SSR_Q_ISE = 4'b1011,
      SSR_Q_ISR = 4'b1100
   } ssr_qsel_t;
endpackage : ssr_pkg
`default_nettype wire

// ### verilog/ssr_evgrp.sv
// One status group: transition filter, latched event register and enable.
`timescale 1ns/10ps
`include "ssr_defs.svh"
`default_nettype none
module ssr_evgrp #(
   parameter logic [`SSR_EW-1:0] POS = `SSR_HW_POS
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [`SSR_EW-1:0] cond,
   input  wire logic              en_wr,
   input  wire logic [`SSR_EW-1:0] en_wdata,
   input  wire logic              rd_clr,
   input  wire logic              cls,
   output logic      [`SSR_EW-1:0] event_q,
   output logic      [`SSR_EW-1:0] enable_q,
   output logic                   summary
);
   logic [`SSR_EW-1:0] prev_r;
   logic [`SSR_EW-1:0] prev_nxt;
   logic [`SSR_EW-1:0] event_r;
   logic [`SSR_EW-1:0] event_nxt;
   logic [`SSR_EW-1:0] enable_r;
   logic [`SSR_EW-1:0] enable_nxt;
   logic [`SSR_EW-1:0] hit;

   // Filter transitions, latch events, and let a new event beat a clear.
   always_comb begin
      hit = (POS & cond & ~prev_r) | (~POS & ~cond & prev_r);
      prev_nxt = cond;
      event_nxt = ((rd_clr || cls) ? `SSR_ZERO16 : event_r) | hit;
      enable_nxt = en_wr ? en_wdata : enable_r;
   end

   // Enable is cleared only by power-on reset.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_r   <= `SSR_ZERO16;
         event_r  <= `SSR_ZERO16;
         enable_r <= `SSR_ZERO16;
      end else begin
         prev_r   <= prev_nxt;
         event_r  <= event_nxt;
         enable_r <= enable_nxt;
      end
   end

   // Group outputs and the summary toward the status byte.
   assign event_q  = event_r;
   assign enable_q = enable_r;
   assign summary  = |(event_r & enable_r);

   AST_EVT_LATCH: assert property (@(posedge clk) disable iff (rst)
      (!rd_clr && !cls) |=> ((event_r & $past(event_r)) == $past(event_r)))
      else $error("Event bit lost without read or clear.");
   AST_EVT_SET: assert property (@(posedge clk) disable iff (rst)
      (|(POS & cond & ~prev_r)) |=> (|(event_r & $past(POS & cond & ~prev_r))))
      else $error("Rising condition did not set its event bit.");
   AST_EN_KEEP: assert property (@(posedge clk) disable iff (rst)
      (cls && !en_wr) |=> (enable_r == $past(enable_r)))
      else $error("Enable changed by clear-status.");
   AST_EN_WRITE: assert property (@(posedge clk) disable iff (rst)
      en_wr |=> (enable_r == $past(en_wdata)))
      else $error("Enable write not stored.");
endmodule : ssr_evgrp
`default_nettype wire

// ### verilog/ssr_top.sv
// Status byte, service request enable, standard events and query port.
`timescale 1ns/10ps
`include "ssr_defs.svh"
`default_nettype none
module ssr_top (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                cls,
   input  wire logic                sre_wr,
   input  wire logic [`SSR_BW-1:0]  sre_wdata,
   input  wire logic                ese_wr,
   input  wire logic [`SSR_BW-1:0]  ese_wdata,
   input  wire logic [`SSR_BW-1:0]  std_evt_set,
   input  wire logic                hse_wr,
   input  wire logic                cse_wr,
   input  wire logic                ise_wr,
   input  wire logic [`SSR_EW-1:0]  en_wdata,
   input  wire logic [`SSR_EW-1:0]  hw_cond,
   input  wire logic [`SSR_EW-1:0]  cp_cond,
   input  wire logic [`SSR_EW-1:0]  in_cond,
   input  wire logic [`SSR_QW-1:0]  err_q_count,
   input  wire logic [`SSR_QW-1:0]  out_q_count,
   input  wire logic                qry_req,
   input  wire ssr_pkg::ssr_qsel_t  qry_sel,
   input  wire logic                spoll_req,
   output logic                     err_q_flush,
   output logic                     srq,
   output logic                     qry_valid,
   output logic      [`SSR_EW-1:0]  qry_data,
   output logic                     spoll_valid,
   output logic      [`SSR_BW-1:0]  spoll_data
);
   logic [`SSR_BW-1:0] sre_r;
   logic [`SSR_BW-1:0] sre_nxt;
   logic [`SSR_BW-1:0] ese_r;
   logic [`SSR_BW-1:0] ese_nxt;
   logic [`SSR_BW-1:0] esr_r;
   logic [`SSR_BW-1:0] esr_nxt;
   logic [`SSR_BW-1:0] masked_prev_r;
   logic               rqs_r;
   logic               rqs_nxt;
   logic               qry_valid_r;
   logic [`SSR_EW-1:0] qry_data_r;
   logic [`SSR_EW-1:0] qry_data_nxt;
   logic               spoll_valid_r;
   logic [`SSR_BW-1:0] spoll_data_r;
   logic [`SSR_BW-1:0] spoll_data_nxt;
   logic [`SSR_BW-1:0] stb;
   logic [`SSR_BW-1:0] stb_mss;
   logic [`SSR_BW-1:0] masked;
   logic               mss;
   logic               new_reason;
   logic               hw_rd;
   logic               cp_rd;
   logic               in_rd;
   logic               hsb;
   logic               csb;
   logic               isb;
   logic [`SSR_EW-1:0] hw_evt;
   logic [`SSR_EW-1:0] hw_en;
   logic [`SSR_EW-1:0] cp_evt;
   logic [`SSR_EW-1:0] cp_en;
   logic [`SSR_EW-1:0] in_evt;
   logic [`SSR_EW-1:0] in_en;

   // A query of an event register clears it as it is read.
   assign hw_rd = qry_req && (qry_sel == ssr_pkg::SSR_Q_HSR);
   assign cp_rd = qry_req && (qry_sel == ssr_pkg::SSR_Q_CSR);
   assign in_rd = qry_req && (qry_sel == ssr_pkg::SSR_Q_ISR);

   // Hardware, coupling and instrument groups.
   ssr_evgrp #(.POS(`SSR_HW_POS)) u_hw (
      .clk      (clk),
      .rst      (rst),
      .cond     (hw_cond),
      .en_wr    (hse_wr),
      .en_wdata (en_wdata),
      .rd_clr   (hw_rd),
      .cls      (cls),
      .event_q  (hw_evt),
      .enable_q (hw_en),
      .summary  (hsb)
   );
   ssr_evgrp #(.POS(`SSR_CP_POS)) u_cp (
      .clk      (clk),
      .rst      (rst),
      .cond     (cp_cond),
      .en_wr    (cse_wr),
      .en_wdata (en_wdata),
      .rd_clr   (cp_rd),
      .cls      (cls),
      .event_q  (cp_evt),
      .enable_q (cp_en),
      .summary  (csb)
   );
   ssr_evgrp #(.POS(`SSR_IN_POS)) u_in (
      .clk      (clk),
      .rst      (rst),
      .cond     (in_cond),
      .en_wr    (ise_wr),
      .en_wdata (en_wdata),
      .rd_clr   (in_rd),
      .cls      (cls),
      .event_q  (in_evt),
      .enable_q (in_en),
      .summary  (isb)
   );

   // Status byte assembly, master summary and request for service.
   always_comb begin
      stb = `SSR_ZERO8;
      stb[`SSR_STB_ISB] = isb;
      stb[`SSR_STB_CSB] = csb;
      stb[`SSR_STB_HSB] = hsb;
      stb[`SSR_STB_MAV] = (out_q_count != `SSR_ZERO8);
      stb[`SSR_STB_ESB] = |(esr_r & ese_r);
      stb[`SSR_STB_ERB] = (err_q_count != `SSR_ZERO8);
      masked = stb & sre_r;
      mss = |masked;
      stb_mss = stb;
      stb_mss[`SSR_STB_MSS] = mss;
      new_reason = |(masked & ~masked_prev_r);
      rqs_nxt = rqs_r;
      if (!mss || spoll_req) begin
         rqs_nxt = 1'b0;
      end
      if (new_reason) begin
         rqs_nxt = 1'b1;
      end
   end

   // Enable and standard event registers; a new event beats a clear.
   always_comb begin
      sre_nxt = sre_wr ? (sre_wdata & `SSR_SRE_MASK) : sre_r;
      ese_nxt = ese_wr ? ese_wdata : ese_r;
      esr_nxt = esr_r;
      if (cls || (qry_req && (qry_sel == ssr_pkg::SSR_Q_ESR))) begin
         esr_nxt = `SSR_ZERO8;
      end
      esr_nxt = esr_nxt | std_evt_set;
   end

   // Query and serial poll answers as unsigned binary integers.
   always_comb begin
      qry_data_nxt = qry_data_r;
      if (qry_req) begin
         unique case (qry_sel)
            ssr_pkg::SSR_Q_STB: qry_data_nxt = {`SSR_ZERO8, stb_mss};
            ssr_pkg::SSR_Q_SRE: qry_data_nxt = {`SSR_ZERO8, sre_r};
            ssr_pkg::SSR_Q_ESE: qry_data_nxt = {`SSR_ZERO8, ese_r};
            ssr_pkg::SSR_Q_ESR: qry_data_nxt = {`SSR_ZERO8, esr_r};
            ssr_pkg::SSR_Q_HCR: qry_data_nxt = hw_cond;
            ssr_pkg::SSR_Q_HSE: qry_data_nxt = hw_en;
            ssr_pkg::SSR_Q_HSR: qry_data_nxt = hw_evt;
            ssr_pkg::SSR_Q_CCR: qry_data_nxt = cp_cond;
            ssr_pkg::SSR_Q_CSE: qry_data_nxt = cp_en;
            ssr_pkg::SSR_Q_CSR: qry_data_nxt = cp_evt;
            ssr_pkg::SSR_Q_ICR: qry_data_nxt = in_cond;
            ssr_pkg::SSR_Q_ISE: qry_data_nxt = in_en;
            ssr_pkg::SSR_Q_ISR: qry_data_nxt = in_evt;
            default:            qry_data_nxt = `SSR_ZERO16;
         endcase
      end
      spoll_data_nxt = spoll_data_r;
      if (spoll_req) begin
         spoll_data_nxt = stb;
         spoll_data_nxt[`SSR_STB_MSS] = rqs_r;
      end
   end

   // Register every piece of state; enables clear only at power-on.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sre_r         <= `SSR_ZERO8;
         ese_r         <= `SSR_ZERO8;
         esr_r         <= `SSR_ZERO8;
         masked_prev_r <= `SSR_ZERO8;
         rqs_r         <= 1'b0;
         qry_valid_r   <= 1'b0;
         qry_data_r    <= `SSR_ZERO16;
         spoll_valid_r <= 1'b0;
         spoll_data_r  <= `SSR_ZERO8;
      end else begin
         sre_r         <= sre_nxt;
         ese_r         <= ese_nxt;
         esr_r         <= esr_nxt;
         masked_prev_r <= masked;
         rqs_r         <= rqs_nxt;
         qry_valid_r   <= qry_req;
         qry_data_r    <= qry_data_nxt;
         spoll_valid_r <= spoll_req;
         spoll_data_r  <= spoll_data_nxt;
      end
   end

   // Outputs; the error queue flush follows clear-status directly.
   assign err_q_flush = cls;
   assign srq         = rqs_r;
   assign qry_valid   = qry_valid_r;
   assign qry_data    = qry_data_r;
   assign spoll_valid = spoll_valid_r;
   assign spoll_data  = spoll_data_r;

   AST_SRE_BIT6: assert property (@(posedge clk) disable iff (rst)
      sre_wr |=> (sre_r == ($past(sre_wdata) & `SSR_SRE_MASK)))
      else $error("Enable bit 6 not discarded.");
   AST_ERB: assert property (@(posedge clk) disable iff (rst)
      (qry_req && qry_sel == ssr_pkg::SSR_Q_STB) |=>
      (qry_data[`SSR_STB_ERB] == $past(err_q_count != `SSR_ZERO8)))
      else $error("Error queue summary wrong.");
   AST_MAV: assert property (@(posedge clk) disable iff (rst)
      (qry_req && qry_sel == ssr_pkg::SSR_Q_STB) |=>
      (qry_data[`SSR_STB_MAV] == $past(out_q_count != `SSR_ZERO8)))
      else $error("Message available bit wrong.");
   AST_RQS_SET: assert property (@(posedge clk) disable iff (rst)
      new_reason |=> srq)
      else $error("New reason did not raise service request.");
   AST_RQS_CLR: assert property (@(posedge clk) disable iff (rst)
      ((!mss || spoll_req) && !new_reason) |=> !srq)
      else $error("Service request not cleared.");
   AST_CLS: assert property (@(posedge clk) disable iff (rst)
      (cls && std_evt_set == `SSR_ZERO8) |=> (esr_r == `SSR_ZERO8))
      else $error("Clear-status left standard events.");
   AST_ESE_READ: assert property (@(posedge clk) disable iff (rst)
      (qry_req && qry_sel == ssr_pkg::SSR_Q_ESE) |=>
      (qry_valid && qry_data == {`SSR_ZERO8, $past(ese_r)}))
      else $error("Standard enable query wrong.");
   AST_HSB: assert property (@(posedge clk) disable iff (rst)
      (qry_req && qry_sel == ssr_pkg::SSR_Q_STB) |=>
      (qry_data[`SSR_STB_HSB] == $past(|(hw_evt & hw_en))))
      else $error("Hardware summary wrong.");
   AST_ESB: assert property (@(posedge clk) disable iff (rst)
      (qry_req && qry_sel == ssr_pkg::SSR_Q_STB) |=>
      (qry_data[`SSR_STB_ESB] == $past(|(esr_r & ese_r))))
      else $error("Event summary bit wrong.");
   AST_STB_LAYOUT: assert property (@(posedge clk) disable iff (rst)
      (qry_req && qry_sel == ssr_pkg::SSR_Q_STB) |=>
      (!qry_data[`SSR_STB_UNUSED] &&
       qry_data[`SSR_EW-1:`SSR_BW] == `SSR_ZERO8))
      else $error("Status byte unused bits set.");
   AST_MSS: assert property (@(posedge clk) disable iff (rst)
      (qry_req && qry_sel == ssr_pkg::SSR_Q_STB) |=>
      (qry_data[`SSR_STB_MSS] == $past(|(stb & sre_r))))
      else $error("Master summary wrong.");
endmodule : ssr_top
`default_nettype wire

// ### dv/ssr_ctl_model.sv
// Bus controller model that serial polls the block when service is asked.
`timescale 1ns/10ps
`default_nettype none
module ssr_ctl_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       poll_en,
   input  wire logic [3:0] poll_dly,
   input  wire logic       srq,
   input  wire logic       spoll_valid,
   input  wire logic [7:0] spoll_data,
   output logic            spoll_req,
   output logic      [7:0] poll_cnt,
   output logic      [7:0] poll_byte
);
   logic [3:0] wait_r;
   logic       busy_r;

   // Waits the chosen number of cycles, polls once, then stays quiet until
   // the answer arrives so that a slow reply is never polled twice.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         spoll_req <= 1'b0;
         busy_r    <= 1'b0;
         wait_r    <= 4'h0;
         poll_cnt  <= 8'h00;
         poll_byte <= 8'h00;
      end else begin
         spoll_req <= 1'b0;
         if (spoll_valid) begin
            busy_r    <= 1'b0;
            poll_cnt  <= poll_cnt + 8'h01;
            poll_byte <= spoll_data;
         end else if (poll_en && srq && !busy_r) begin
            if (wait_r == poll_dly) begin
               spoll_req <= 1'b1;
               busy_r    <= 1'b1;
               wait_r    <= 4'h0;
            end else begin
               wait_r <= wait_r + 4'h1;
            end
         end
      end
   end
endmodule : ssr_ctl_model
`default_nettype wire

// ### dv/tb_status_service_request.sv
// Self-checking bench for the status byte and service request block.
`timescale 1ns/10ps
`default_nettype none
module tb_status_service_request;
   logic               clk, rst, cls, sre_wr, ese_wr, hse_wr, cse_wr;
   logic               ise_wr, qry_req, poll_en, err_q_flush, srq;
   logic               qry_valid, spoll_req, spoll_valid;
   logic [7:0]         sre_wdata, ese_wdata, std_evt_set, err_q_count;
   logic [7:0]         out_q_count, spoll_data, poll_byte, poll_cnt;
   logic [7:0]         sre_m, b, pc;
   logic [15:0]        en_wdata, hw_cond, cp_cond, in_cond, qry_data;
   logic [15:0]        d, en_m, cm;
   logic [3:0]         poll_dly;
   ssr_pkg::ssr_qsel_t qry_sel;
   integer             seed, fails, checks_done, i, g, k;

   ssr_top dut_u (.clk, .rst, .cls, .sre_wr, .sre_wdata, .ese_wr, .ese_wdata,
      .std_evt_set, .hse_wr, .cse_wr, .ise_wr, .en_wdata, .hw_cond, .cp_cond,
      .in_cond, .err_q_count, .out_q_count, .qry_req, .qry_sel, .spoll_req,
      .err_q_flush, .srq, .qry_valid, .qry_data, .spoll_valid, .spoll_data);

   ssr_ctl_model ctl_u (.clk, .rst, .poll_en, .poll_dly, .srq, .spoll_valid,
      .spoll_data, .spoll_req, .poll_cnt, .poll_byte);

   // Free-running system clock at 40 MHz.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Status byte as the host sees it: bits 0 and 6 dropped, summary in 6.
   function automatic logic [7:0] stb_f(input logic [7:0] v,
                                        input logic [7:0] s);
      logic [7:0] r;
      r = v & 8'hBE;
      r[6] = |(r & s & 8'hBF);
      return r;
   endfunction : stb_f

   function automatic ssr_pkg::ssr_qsel_t sel(input integer n);
      return ssr_pkg::ssr_qsel_t'(n[3:0]);
   endfunction : sel

   task automatic tick;
      @(posedge clk);
      #1;
   endtask : tick

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Writes one enable: 0 service, 1 standard, 2..4 the three groups.
   task automatic wr(input integer n, input logic [15:0] v);
      sre_wdata = v[7:0];
      ese_wdata = v[7:0];
      en_wdata = v;
      {sre_wr, ese_wr, hse_wr, cse_wr, ise_wr} = 5'h10 >> n;
      tick;
      {sre_wr, ese_wr, hse_wr, cse_wr, ise_wr} = 5'h00;
      // Let an edge pass so that a following write starts cleanly.
      tick;
   endtask : wr

   // Query pulse; the answer is expected exactly one cycle later.
   task automatic qry(input ssr_pkg::ssr_qsel_t s);
      qry_req = 1'b1;
      qry_sel = s;
      tick;
      chk({15'h0000, qry_valid}, 16'h0001);
      d = qry_data;
      qry_req = 1'b0;
      tick;
      chk({15'h0000, qry_valid}, 16'h0000);
   endtask : qry

   task automatic wait_srq(input logic v);
      i = 0;
      while (srq !== v && i < 8) begin
         tick;
         i++;
      end
      chk({15'h0000, srq}, {15'h0000, v});
   endtask : wait_srq

   task automatic test_done;
      $display("Checks made %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done

   // Watchdog sized well above the few hundred cycles the tests need.
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      $display("ERROR at %0t: watchdog expired", $time);
      test_done;
   end

   // Main sequence: reset values, enables, status byte, groups, clear, poll.
   initial begin
      seed = 61;
      fails = 0;
      checks_done = 0;
      {rst, cls, sre_wr, ese_wr, hse_wr, cse_wr, ise_wr, qry_req} = 8'h80;
      {sre_wdata, ese_wdata, std_evt_set, err_q_count, out_q_count} = 40'h0;
      {en_wdata, hw_cond, cp_cond, in_cond} = 64'h0;
      {poll_en, poll_dly} = 5'h00;
      qry_sel = ssr_pkg::SSR_Q_STB;
      repeat (12) @(posedge clk);
      #1 rst = 1'b0;
      for (g = 0; g < 13; g++) begin
         qry(sel(g));
         chk(d, 16'h0000);
      end
      for (g = 0; g < 8; g++) begin
         sre_m = 8'($random(seed));
         wr(0, {8'h00, sre_m});
         qry(ssr_pkg::SSR_Q_SRE);
         chk(d, {8'h00, sre_m & 8'hBF});
         err_q_count = (g % 3 == 0) ? 8'h00 : 8'($random(seed));
         out_q_count = (g % 2 == 0) ? 8'h00 : 8'($random(seed));
         b = {err_q_count != 8'h00, 2'b00, out_q_count != 8'h00, 4'h0};
         qry(ssr_pkg::SSR_Q_STB);
         chk(d, {8'h00, stb_f(b, sre_m)});
      end
      {err_q_count, out_q_count} = 16'h0000;
      wr(0, 16'h0000);
      for (g = 0; g < 3; g++) begin
         k = $random(seed) & 15;
         en_m = 16'h0001 << k;
         cm = en_m | (16'h0001 << ((k + 3) & 15));
         wr(2 + g, en_m);
         if (g == 0) hw_cond = cm;
         else if (g == 1) cp_cond = cm;
         else in_cond = cm;
         tick;
         qry(sel(4 + 3 * g));
         chk(d, cm);
         qry(sel(5 + 3 * g));
         chk(d, en_m);
         qry(ssr_pkg::SSR_Q_STB);
         chk(d, 16'h0001 << (3 - g));
         qry(sel(6 + 3 * g));
         chk(d, cm);
         qry(sel(6 + 3 * g));
         chk(d, 16'h0000);
      end
      wr(1, 16'h00FF);
      std_evt_set = 8'h01 << ($random(seed) & 7);
      hw_cond = 16'h0000;
      tick;
      {std_evt_set, hw_cond} = 24'h000001;
      tick;
      qry(ssr_pkg::SSR_Q_STB);
      chk(d & 16'h0020, 16'h0020);
      cls = 1'b1;
      #1 chk({15'h0000, err_q_flush}, 16'h0001);
      tick;
      cls = 1'b0;
      qry(ssr_pkg::SSR_Q_ESR);
      chk(d, 16'h0000);
      qry(ssr_pkg::SSR_Q_HSR);
      chk(d, 16'h0000);
      qry(ssr_pkg::SSR_Q_ESE);
      chk(d, 16'h00FF);
      out_q_count = 8'h01;
      for (g = 0; g < 2; g++) begin
         wr(0, 16'h0000);
         wr(0, 16'h0010);
         wait_srq(1'b1);
         poll_dly = (g == 0) ? 4'h0 : 4'($random(seed));
         poll_en = 1'b1;
         pc = poll_cnt;
         for (i = 0; i < 30 && poll_cnt === pc; i++) tick;
         poll_en = 1'b0;
         chk({8'h00, poll_byte}, 16'h0050);
         chk({15'h0000, srq}, 16'h0000);
      end
      wr(0, 16'h0000);
      wr(0, 16'h0010);
      wait_srq(1'b1);
      out_q_count = 8'h00;
      wait_srq(1'b0);
      test_done;
   end
endmodule : tb_status_service_request
`default_nettype wire
